// >>> rtl/gdcr_pkg.sv
package gdcr_pkg;
	// ------------------------------------------------------------
	// link command and response identifiers
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_GET_CFG_ZERO = 8'h02;
	localparam logic [7:0] CMD_READ_CONFIG_TWO = 8'h08;
	localparam logic [7:0] CMD_SET_CFG_ZERO = 8'h82;
	localparam logic [7:0] CMD_SET_CFG_TWO = 8'h87;
	localparam logic [7:0] RSP_CFG_ZERO_ID = 8'h02;
	localparam logic [7:0] RSP_CFG_TWO_ID = 8'h08;
	localparam logic [7:0] RSP_SET_CFG_TWO_ID = 8'h07;
	localparam logic [7:0] RSP_ACK_BIT = 8'h40;
	// ------------------------------------------------------------
	// configuration register 0 fields
	// ------------------------------------------------------------
	localparam int DCZ_SLEEP_POS = 5;
	localparam int DCZ_UVLO_POS = 3;
	localparam int DCZ_SHORT_POS = 2;
	localparam int DCZ_OC_LSB = 0;
	localparam logic [7:0] DCZ_WRITE_MASK = 8'h2f;
	localparam logic [7:0] DCZ_RESET = 8'h00;
	localparam logic [1:0] OC_LIMIT_RESET = 2'h0;
	// ------------------------------------------------------------
	// configuration register 2 fields
	// ------------------------------------------------------------
	localparam int CFG2_DT_LSB = 2;
	localparam int CFG2_BL_LSB = 0;
	localparam logic [2:0] DEAD_TIME_RESET = 3'h0;
	localparam logic [1:0] BLANK_TIME_RESET = 2'h0;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 25;
	localparam int OE_LOW_TIME_US = 1000;
	localparam int OE_LOW_CYCLES = OE_LOW_TIME_US * CLK_MHZ;
	localparam int TIMER_W = 16;
	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_RUN = 2'b00,
		MODE_STANDBY = 2'b01,
		MODE_SLEEP = 2'b10
	} gdcr_mode_t;
	typedef enum logic [1:0] {
		LINK_IDLE = 2'b00,
		LINK_WAIT_DATA = 2'b01,
		LINK_SEND_TWO = 2'b10
	} gdcr_link_t;
endpackage : gdcr_pkg

// >>> rtl/gdcr_oe_timer.sv
`timescale 1ns/1ps
module gdcr_oe_timer
	import gdcr_pkg::*;
#(
	parameter logic [TIMER_W-1:0] LIMIT = TIMER_W'(OE_LOW_CYCLES)
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// level in, expiry out
	input wire logic oe_low,
	output logic expired
);
	logic [TIMER_W-1:0] count;
	logic [TIMER_W-1:0] next_count;
	logic next_expired;

	// saturating count so a long low never wraps back
	always_comb begin
		next_count = count;
		next_expired = expired;
		if (!oe_low) begin
			next_count = '0;
			next_expired = 1'b0;
		end else if (count != LIMIT) begin
			next_count = count + 1'b1;
		end else begin
			next_expired = 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count <= '0;
			expired <= 1'b0;
		end else begin
			count <= next_count;
			expired <= next_expired;
		end
	end
endmodule : gdcr_oe_timer

// >>> rtl/gdcr_top.sv
// Summary of operation
// R1 - config-two reply first byte 08h nack, 48h ack
// R2 - reply byte two bits 4:2 dead time
// R3 - reply bits 1:0 blanking time, 7:5 reserved
// R4 - sleep bit changes only while in standby
// R5 - enable low: sleep if bit set, else standby
// R6 - bit 3 disables mosfet undervoltage lockout
// R7 - bit 2 disables mosfet short detection
// R8 - bits 1:0 code 11 1.0V, 10 0.75V
// R9 - code 01 0.5V, 00 0.25V default
// R10 - mode entered after enable low over 1 ms
// R11 - unimplemented and reserved bits are zero
`timescale 1ns/1ps
module gdcr_top
	import gdcr_pkg::*;
#(
	parameter logic [TIMER_W-1:0] OE_LOW_LIMIT = TIMER_W'(OE_LOW_CYCLES)
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// driver message link, received bytes
	input wire logic rx_valid,
	input wire logic [7:0] rx_byte,
	// driver message link, response bytes
	output logic tx_valid,
	output logic [7:0] tx_byte,
	// output enable pin
	input wire logic output_enable,
	// power mode
	output logic sleep_mode,
	output logic standby_mode,
	// configuration towards the driver stage
	output logic ext_fet_uvlo_disable,
	output logic ext_fet_short_detect_disable,
	output logic [1:0] ext_fet_overcurrent_limit_sel,
	output logic [2:0] dead_time_sel,
	output logic [1:0] blanking_time_sel
);
	// ------------------------------------------------------------
	// power mode
	// ------------------------------------------------------------
	logic oe_expired;
	logic sleep_sel;
	gdcr_mode_t mode;
	gdcr_mode_t next_mode;
	logic next_sleep_mode;
	logic next_standby_mode;

	gdcr_oe_timer #(
		.LIMIT(OE_LOW_LIMIT)
	) u_oe_timer (
		.clk(clk),
		.rst(rst),
		.oe_low(!output_enable),
		.expired(oe_expired)
	);

	always_comb begin
		next_mode = mode;
		// mode is latched: a sleep bit written in standby waits for the next low period
		if (output_enable) begin
			next_mode = MODE_RUN;
		end else if (oe_expired && mode == MODE_RUN) begin
			next_mode = sleep_sel ? MODE_SLEEP : MODE_STANDBY; // R5 R10
		end
		next_sleep_mode = (next_mode == MODE_SLEEP);
		next_standby_mode = (next_mode == MODE_STANDBY);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mode <= MODE_RUN;
			sleep_mode <= 1'b0;
			standby_mode <= 1'b0;
		end else begin
			mode <= next_mode;
			sleep_mode <= next_sleep_mode;
			standby_mode <= next_standby_mode;
		end
	end

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	logic [7:0] cfg_zero;
	logic [7:0] next_cfg_zero;
	logic [2:0] next_dead_time;
	logic [1:0] next_blank_time;
	logic [7:0] cfg_two;
	logic in_standby;
	logic next_uvlo_disable;
	logic next_short_disable;
	logic [1:0] next_oc_sel;

	assign sleep_sel = cfg_zero[DCZ_SLEEP_POS];
	assign in_standby = (mode == MODE_STANDBY);
	assign cfg_two = {3'h0, dead_time_sel, blanking_time_sel}; // R2 R3 R11

	// ------------------------------------------------------------
	// link sequencer
	// ------------------------------------------------------------
	gdcr_link_t link;
	gdcr_link_t next_link;
	logic [7:0] pend_cmd;
	logic [7:0] next_pend_cmd;
	logic [7:0] hold_byte;
	logic [7:0] next_hold_byte;
	logic next_tx_valid;
	logic [7:0] next_tx_byte;
	logic [7:0] wr_value;
	logic sleep_change;
	logic blank_change;

	always_comb begin
		next_link = link;
		next_pend_cmd = pend_cmd;
		next_hold_byte = hold_byte;
		next_tx_valid = 1'b0;
		next_tx_byte = tx_byte;
		next_cfg_zero = cfg_zero;
		next_dead_time = dead_time_sel;
		next_blank_time = blanking_time_sel;
		wr_value = rx_byte & DCZ_WRITE_MASK; // R11
		sleep_change = wr_value[DCZ_SLEEP_POS] != sleep_sel;
		blank_change = rx_byte[CFG2_BL_LSB +: 2] != blanking_time_sel;
		case (link)
			LINK_IDLE: begin
				if (rx_valid) begin
					case (rx_byte)
						CMD_READ_CONFIG_TWO: begin
							next_tx_valid = 1'b1;
							next_tx_byte = RSP_CFG_TWO_ID | RSP_ACK_BIT; // R1
							next_hold_byte = cfg_two; // R2 R3
							next_link = LINK_SEND_TWO;
						end
						CMD_GET_CFG_ZERO: begin
							next_tx_valid = 1'b1;
							next_tx_byte = RSP_CFG_ZERO_ID | RSP_ACK_BIT;
							next_hold_byte = cfg_zero;
							next_link = LINK_SEND_TWO;
						end
						CMD_SET_CFG_ZERO, CMD_SET_CFG_TWO: begin
							next_pend_cmd = rx_byte;
							next_link = LINK_WAIT_DATA;
						end
						// unknown identifiers are dropped silently
						default: begin
							next_link = LINK_IDLE;
						end
					endcase
				end
			end
			LINK_WAIT_DATA: begin
				if (rx_valid) begin
					next_tx_valid = 1'b1;
					next_link = LINK_SEND_TWO;
					if (pend_cmd == CMD_SET_CFG_ZERO) begin
						// refuse the whole write rather than apply it in part
						if (sleep_change && !in_standby) begin
							next_tx_byte = RSP_CFG_ZERO_ID; // R4
							next_hold_byte = cfg_zero;
						end else begin
							next_cfg_zero = wr_value; // R6 R7 R8 R9
							next_tx_byte = RSP_CFG_ZERO_ID | RSP_ACK_BIT;
							next_hold_byte = wr_value;
						end
					end else begin
						if (blank_change && !in_standby) begin
							next_tx_byte = RSP_SET_CFG_TWO_ID;
							next_hold_byte = cfg_two;
						end else begin
							next_dead_time = rx_byte[CFG2_DT_LSB +: 3];
							next_blank_time = rx_byte[CFG2_BL_LSB +: 2];
							next_tx_byte = RSP_SET_CFG_TWO_ID | RSP_ACK_BIT;
							next_hold_byte = {3'h0, rx_byte[4:0]}; // R11
						end
					end
				end
			end
			LINK_SEND_TWO: begin
				// bytes arriving while the first reply byte is on tx_byte are ignored
				next_tx_valid = 1'b1;
				next_tx_byte = hold_byte;
				next_link = LINK_IDLE;
			end
			default: begin
				next_link = LINK_IDLE;
			end
		endcase
		// outputs follow the stored image of register zero
		next_uvlo_disable = next_cfg_zero[DCZ_UVLO_POS]; // R6
		next_short_disable = next_cfg_zero[DCZ_SHORT_POS]; // R7
		next_oc_sel = next_cfg_zero[DCZ_OC_LSB +: 2]; // R8 R9
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			link <= LINK_IDLE;
			pend_cmd <= 8'h00;
			hold_byte <= 8'h00;
			tx_valid <= 1'b0;
			tx_byte <= 8'h00;
			cfg_zero <= DCZ_RESET;
			dead_time_sel <= DEAD_TIME_RESET;
			blanking_time_sel <= BLANK_TIME_RESET;
			ext_fet_uvlo_disable <= 1'b0;
			ext_fet_short_detect_disable <= 1'b0;
			ext_fet_overcurrent_limit_sel <= OC_LIMIT_RESET;
		end else begin
			link <= next_link;
			pend_cmd <= next_pend_cmd;
			hold_byte <= next_hold_byte;
			tx_valid <= next_tx_valid;
			tx_byte <= next_tx_byte;
			cfg_zero <= next_cfg_zero;
			dead_time_sel <= next_dead_time;
			blanking_time_sel <= next_blank_time;
			ext_fet_uvlo_disable <= next_uvlo_disable; // R6
			ext_fet_short_detect_disable <= next_short_disable; // R7
			ext_fet_overcurrent_limit_sel <= next_oc_sel; // R8 R9
		end
	end
endmodule : gdcr_top

// >>> dv/gdcr_host.sv
`timescale 1ns/1ps
module gdcr_host (
	// link towards the driver
	input logic clk,
	output logic rx_valid,
	output logic [7:0] rx_byte,
	input logic tx_valid,
	input logic [7:0] tx_byte
);
	logic [7:0] b1, b2;
	initial begin
		rx_valid = 1'b0;
		rx_byte = 8'h00;
	end
	// command, optional data byte, then the two reply bytes
	task automatic xfer(input logic [7:0] c, d, input bit w);
		int n = 0;
		@(posedge clk) rx_valid <= 1'b1;
		rx_byte <= c;
		if (w) begin
			@(posedge clk) rx_byte <= d;
		end
		// released line shows inverse of last byte, not a stale copy
		@(posedge clk) rx_valid <= 1'b0;
		rx_byte <= ~rx_byte;
		#1;
		while (tx_valid !== 1'b1 && n < 20) begin
			@(posedge clk) #1;
			n++;
		end
		// a reply that never comes turns into unknowns, which every check refuses
		b1 = (n < 20) ? tx_byte : 8'hxx;
		@(posedge clk) #1;
		b2 = (n < 20) ? tx_byte : 8'hxx;
	endtask : xfer
endmodule : gdcr_host

// >>> dv/gdcr_chk.sv
`timescale 1ns/1ps
module gdcr_chk
	import gdcr_pkg::*;
#(
	parameter logic [TIMER_W-1:0] OE_LOW_LIMIT = TIMER_W'(OE_LOW_CYCLES)
) (
	// clock and reset
	input logic clk,
	input logic rst,
	// link
	input logic rx_valid,
	input logic [7:0] rx_byte,
	input logic tx_valid,
	input logic [7:0] tx_byte,
	// power mode
	input logic output_enable,
	input logic sleep_mode,
	input logic standby_mode,
	// configuration outputs
	input logic ext_fet_uvlo_disable,
	input logic ext_fet_short_detect_disable,
	input logic [1:0] ext_fet_overcurrent_limit_sel,
	input logic [2:0] dead_time_sel,
	input logic [1:0] blanking_time_sel
);
	// saturating count of low enable samples
	logic [15:0] low_n;
	always_ff @(posedge clk or posedge rst)
		if (rst) low_n <= '0;
		else low_n <= output_enable ? '0 : 16'(low_n + 16'(low_n != 16'hffff));
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	chk_mode_late: assert property ((sleep_mode || standby_mode) |-> low_n > OE_LOW_LIMIT)
		else $error("mode too early");
	chk_mode_due: assert property (low_n == OE_LOW_LIMIT + 16'd3 |-> sleep_mode || standby_mode)
		else $error("mode too late");
	chk_run_back: assert property (output_enable |=> !sleep_mode && !standby_mode)
		else $error("no return to run");
	chk_mode_excl: assert property (!(sleep_mode && standby_mode))
		else $error("two modes");
	chk_reply_pair: assert property ($rose(tx_valid) |=> tx_valid)
		else $error("single reply byte");
	chk_cfg2_ack: assert property ($rose(tx_valid) && tx_byte[3:0] == 4'h8 |-> tx_byte == 8'h48)
		else $error("bad cfg2 id");
	chk_cfg2_body: assert property (tx_valid && $past(tx_valid) && $past(tx_byte) == 8'h48
		|-> tx_byte == {3'h0, dead_time_sel, blanking_time_sel})
		else $error("bad cfg2 body");
	chk_zero_body: assert property (tx_valid && $past(tx_valid) && $past(tx_byte[5:0]) == 6'h02
		|-> tx_byte[7:6] == 2'h0 && !tx_byte[4] && tx_byte[3:0] == {ext_fet_uvlo_disable,
		ext_fet_short_detect_disable, ext_fet_overcurrent_limit_sel})
		else $error("bad config zero body");
	chk_cfg_write: assert property ($changed({ext_fet_uvlo_disable, ext_fet_short_detect_disable,
		ext_fet_overcurrent_limit_sel}) |-> tx_valid && tx_byte == 8'h42)
		else $error("config zero moved");
	chk_dt_write: assert property ($changed({dead_time_sel, blanking_time_sel})
		|-> tx_valid && tx_byte == 8'h47)
		else $error("cfg2 moved");
	cov_standby: cover property (standby_mode);
	cov_sleep: cover property (sleep_mode);
	cov_nack: cover property (tx_valid && tx_byte == 8'h02);
endmodule : gdcr_chk
bind gdcr_top gdcr_chk #(.OE_LOW_LIMIT(OE_LOW_LIMIT)) chk_i (.*);

// >>> dv/testbench.sv
`timescale 1ns/1ps
module testbench;
	import gdcr_pkg::*;
	localparam int LIM = 8;
	logic clk, rst, output_enable, rx_valid, tx_valid, sleep_mode, standby_mode;
	logic ext_fet_uvlo_disable, ext_fet_short_detect_disable;
	logic [7:0] rx_byte, tx_byte, cfg_z, d, e;
	logic [1:0] ext_fet_overcurrent_limit_sel, blanking_time_sel;
	logic [2:0] dead_time_sel;
	int seed = 56156;
	int miscompares = 0;
	int num_checks = 0;
	gdcr_top #(.OE_LOW_LIMIT(TIMER_W'(LIM))) uut (.*);
	gdcr_host host (.*);
	task check(input logic [7:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task conclude;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : conclude
	function logic [7:0] exp_cfg_z(input logic [7:0] v);
		return v & DCZ_WRITE_MASK;
	endfunction : exp_cfg_z
	// register two keeps bits 4:0, reserved bits read zero
	function logic [7:0] exp_cfg_two(input logic [7:0] v);
		return {3'h0, v[4:0]};
	endfunction : exp_cfg_two
	// drop enable, mode must wait past the limit
	task low_period;
		@(posedge clk) output_enable <= 1'b0;
		repeat (LIM) @(posedge clk);
		#1 check({6'h0, sleep_mode, standby_mode}, 8'h00);
		repeat (3) @(posedge clk);
		#1 check({6'h0, sleep_mode, standby_mode}, {6'h0, cfg_z[5], ~cfg_z[5]});
	endtask : low_period
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		#120000;
		miscompares++;
		conclude;
	end
	initial begin
		rst = 1'b1;
		output_enable = 1'b1;
		cfg_z = 8'h00;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		host.xfer(CMD_READ_CONFIG_TWO, 8'h00, 0);
		check(host.b1, 8'h48);
		check(host.b2, 8'h00);
		host.xfer(CMD_GET_CFG_ZERO, 8'h00, 0);
		check(host.b2, 8'h00);
		low_period;
		// all field codes, random upper bits
		for (int i = 0; i < 8; i++) begin
			d = 8'($random(seed));
			d[1:0] = i[1:0];
			if (i == 7) d[5] = 1'b1;
			host.xfer(CMD_SET_CFG_ZERO, d, 1);
			cfg_z = exp_cfg_z(d);
			check(host.b1, 8'h42);
			check(host.b2, cfg_z);
			check({4'h0, ext_fet_uvlo_disable, ext_fet_short_detect_disable,
				ext_fet_overcurrent_limit_sel}, {4'h0, cfg_z[3:0]});
			e = {d[7:5], i[2:0], i[1:0]};
			host.xfer(CMD_SET_CFG_TWO, e, 1);
			check(host.b1, 8'h47);
			check(host.b2, exp_cfg_two(e));
			check({3'h0, dead_time_sel, blanking_time_sel}, exp_cfg_two(e));
			host.xfer(CMD_READ_CONFIG_TWO, 8'h00, 0);
			check(host.b2, exp_cfg_two(e));
		end
		// leaving standby locks the sleep bit and the blanking code
		@(posedge clk) output_enable <= 1'b1;
		host.xfer(CMD_SET_CFG_ZERO, cfg_z ^ 8'h20, 1);
		check(host.b1, 8'h02);
		check(host.b2, cfg_z);
		host.xfer(CMD_SET_CFG_TWO, e ^ 8'h01, 1);
		check(host.b1, 8'h07);
		check(host.b2, exp_cfg_two(e));
		check({3'h0, dead_time_sel, blanking_time_sel}, exp_cfg_two(e));
		low_period;
		conclude;
	end
endmodule : testbench
